// ===== tb/tb_top.sv
// Self-checking bench for the USB interrupt flag block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clock_in = 1'b0;
  logic                reset_in = 1'b1;
  logic [7:0]          addr = 8'h00;
  logic [31:0]         wdata = 32'h0;
  logic                wr_s = 1'b0;
  logic                rd_s = 1'b0;
  uif_pkg::uif_event_t ev = 7'h00;
  logic [7:0]          err_ev = 8'h00;
  logic                k_hold = 1'b0;
  logic                lk, li, ls, la, irq, men, hst, adv, adv_seen;
  logic [31:0]         rdata, d;
  int                  miscompares = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;
  logic [22:0]         rows [7] = '{{8'h01, 7'h40, 8'h80}, {8'h01, 7'h20, 8'h04},
                                    {8'h01, 7'h08, 8'h08}, {8'h01, 7'h04, 8'h01},
                                    {8'h03, 7'h10, 8'h04}, {8'h03, 7'h02, 8'h01},
                                    {8'h03, 7'h01, 8'h40}};

  always #4 clock_in = !clock_in;

  uif_bus_model bus_u (.clock_in(clock_in), .k_hold_in(k_hold), .line_k_out(lk),
    .line_idle_out(li), .line_se0_out(ls), .line_activity_out(la));

  uif_core dut_u (.clock_in(clock_in), .reset_in(reset_in), .addr_in(addr),
    .wdata_in(wdata), .write_in(wr_s), .read_in(rd_s), .events_in(ev),
    .error_events_in(err_ev), .line_k_in(lk), .line_idle_in(li), .line_se0_in(ls),
    .line_activity_in(la), .engine_busy_in(1'b0), .token_status_in(8'h5A),
    .rdata_out(rdata), .module_interrupt_request_out(irq), .module_enable_out(men),
    .host_mode_out(hst), .token_fifo_advance_out(adv));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_in);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= v;
    #1 adv_seen = adv;
    @(posedge clock_in);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic pulse(input logic [6:0] e, input logic [7:0] er);
    @(posedge clock_in);
    ev     <= e;
    err_ev <= er;
    @(posedge clock_in);
    ev     <= 7'h00;
    err_ev <= 8'h00;
    repeat (2) @(posedge clock_in);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // The ceiling is a few times the expected run of about 1000 cycles.
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(8'h04); check(d, 32'h0);
    rd(8'h08); check(d, 32'h0);
    rd(8'h00); check(d, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(8'h00, {24'h0, rows[i][22:15]});
      #1 check(men, 1'b1);
      wr(8'h08, 32'hFF);
      // Attach only counts once the bus has been quiet long enough.
      if (rows[i][14:8] == 7'h01)
        repeat (320) @(posedge clock_in);
      pulse(rows[i][14:8], 8'h00);
      rd(8'h04); check(d, {24'h0, rows[i][7:0]});
      check(irq, 1'b1);
      wr(8'h04, 32'h0);
      rd(8'h04); check(d, {24'h0, rows[i][7:0]});
      wr(8'h04, {24'h0, rows[i][7:0]});
      check(adv_seen, rows[i][7:0] == 8'h08);
      rd(8'h04); check(d, 32'h0);
      check(irq, 1'b0);
    end
    $display("event table done");
    rd(8'h00); check(d[3], 1'b1);
    rd(8'h14); check(d, 32'h5A);
    rd(8'h20); check(d, 32'h0);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08); check(d, 32'hFF);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04); check(d, 32'h0);
    $display("register test done");
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h01);
    pulse(7'h00, 8'h01);
    rd(8'h04); check(d, 32'h02);
    check(irq, 1'b0);
    wr(8'h08, 32'h02);
    #1 check(irq, 1'b1);
    wr(8'h04, 32'h02);
    rd(8'h04); check(d, 32'h02);
    wr(8'h10, 32'h01);
    repeat (2) @(posedge clock_in);
    rd(8'h04); check(d, 32'h0);
    $display("error test done");
    // Resume stays masked outside suspend, as software must keep it.
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h01);
    k_hold <= 1'b1;
    repeat (330) @(posedge clock_in);
    k_hold <= 1'b0;
    rd(8'h04); check(d, 32'h20);
    wr(8'h04, 32'h20);
    $display("resume test done");
    wr(8'h08, 32'hFF);
    wr(8'h00, 32'h0);
    #1 check(men, 1'b0);
    rd(8'h00); check(d, 32'h08);
    pulse(7'h40, 8'h00);
    rd(8'h04); check(d, 32'h0);
    check(irq, 1'b0);
    repeat (40) @(posedge clock_in);
    rd(8'h00); check(d, 32'h0);
    $display("power test done");
    // A reset in mid-run must clear the enables that were left set.
    @(posedge clock_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(8'h08); check(d, 32'h0);
    $display("second reset test done");
    print_verdict();
  end
endmodule

// ===== tb/uif_bus_model.sv
// Behavioural model of the cable side: line levels seen by the block.
module uif_bus_model
(
  input  wire logic clock_in,
  input  wire logic k_hold_in,
  output logic      line_k_out,
  output logic      line_idle_out,
  output logic      line_se0_out,
  output logic      line_activity_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // The line is quiet and never SE0, so attach stays qualified in host mode.
  always @(posedge clock_in)
  begin
    line_k_out        <= k_hold_in;
    line_idle_out     <= !k_hold_in;
    line_se0_out      <= 1'b0;
    line_activity_out <= 1'b0;
  end
endmodule

// ===== verilog/uif_core.sv
// USB interrupt flags, enables, error summary, power enable and busy status.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`include "uif_defines.svh"

module uif_core
(
  input  wire logic               clock_in,
  input  wire logic               reset_in,
  input  wire logic [7:0]         addr_in,
  input  wire logic [31:0]        wdata_in,
  input  wire logic               write_in,
  input  wire logic               read_in,
  input  wire uif_pkg::uif_event_t events_in,
  input  wire logic [7:0]         error_events_in,
  input  wire logic               line_k_in,
  input  wire logic               line_idle_in,
  input  wire logic               line_se0_in,
  input  wire logic               line_activity_in,
  input  wire logic               engine_busy_in,
  input  wire logic [7:0]         token_status_in,
  output logic [31:0]             rdata_out,
  output logic                    module_interrupt_request_out,
  output logic                    module_enable_out,
  output logic                    host_mode_out,
  output logic                    token_fifo_advance_out
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  uif_pkg::uif_state_t st;
  uif_pkg::uif_state_t next_st;
  logic [7:0]          set_flags;
  logic [7:0]          clr_flags;
  logic [7:0]          clr_err;
  logic                error_summary_flag;
  logic                on;
  logic                wr_flags;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    on      = st.power_enable;
    // Line levels come from the pad side, so two flops precede any use.
    next_st.line_s1 = {line_k_in, line_idle_in};
    next_st.line_s2 = st.line_s1;
    next_st.aux_s1  = {line_se0_in, line_activity_in};
    next_st.aux_s2  = st.aux_s1;

    wr_flags  = write_in && hit(addr_in, `UIF_OFS_FLAGS);
    clr_flags = wr_flags ? wdata_in[7:0] : `UIF_ZERO8;
    clr_flags[`UIF_BIT_ERROR] = 1'b0;
    clr_err   = (write_in && hit(addr_in, `UIF_OFS_ERR_FLAGS)) ? wdata_in[7:0] : `UIF_ZERO8;

    // Resume: K held for 2.5 us.
    if (on && st.line_s2[1])
    begin
      if (st.k_cnt != `UIF_CNT_W'(`UIF_K_CYCLES))
        next_st.k_cnt = st.k_cnt + 1'b1;
    end
    else
      next_st.k_cnt = '0;
    // Idle: continuous 3 ms.
    if (on && st.line_s2[0])
    begin
      if (st.idle_cnt != `UIF_CNT_W'(`UIF_IDLE_CYCLES))
        next_st.idle_cnt = st.idle_cnt + 1'b1;
    end
    else
      next_st.idle_cnt = '0;
    // Quiet bus time for attach qualification.
    if (on && !st.aux_s2[0])
    begin
      if (st.quiet_cnt != `UIF_CNT_W'(`UIF_QUIET_CYCLES))
        next_st.quiet_cnt = st.quiet_cnt + 1'b1;
    end
    else
      next_st.quiet_cnt = '0;

    // One event per episode, so a long idle does not refire after a clear.
    next_st.k_seen    = (st.k_cnt == `UIF_CNT_W'(`UIF_K_CYCLES));
    next_st.idle_seen = (st.idle_cnt == `UIF_CNT_W'(`UIF_IDLE_CYCLES));

    set_flags = `UIF_ZERO8;
    set_flags[`UIF_BIT_STALL]  = events_in.stall;
    set_flags[`UIF_BIT_ATTACH] = events_in.attach && st.host_mode && !st.aux_s2[1]
                                 && (st.quiet_cnt == `UIF_CNT_W'(`UIF_QUIET_CYCLES));
    set_flags[`UIF_BIT_RESUME] = next_st.k_seen && !st.k_seen;
    set_flags[`UIF_BIT_IDLE]   = next_st.idle_seen && !st.idle_seen;
    set_flags[`UIF_BIT_TOKEN]  = events_in.token_done;
    set_flags[`UIF_BIT_SOF]    = st.host_mode ? events_in.sof_threshold
                                              : events_in.sof_rx;
    set_flags[`UIF_BIT_RESET]  = st.host_mode ? events_in.detach
                                              : events_in.bus_reset;
    if (!on)
      set_flags = `UIF_ZERO8;

    // Set wins over a simultaneous clear.
    next_st.flags     = (st.flags & ~clr_flags) | set_flags;
    next_st.err_flags = (st.err_flags & ~clr_err) | (on ? error_events_in : `UIF_ZERO8);
    error_summary_flag = |(st.err_flags & st.err_enables);
    next_st.flags[`UIF_BIT_ERROR] = error_summary_flag;

    if (write_in && hit(addr_in, `UIF_OFS_ENABLES))
      next_st.enables = wdata_in[7:0];
    if (write_in && hit(addr_in, `UIF_OFS_ERR_ENABLE))
      next_st.err_enables = wdata_in[7:0];
    if (write_in && hit(addr_in, `UIF_OFS_POWER))
    begin
      next_st.power_enable = wdata_in[`UIF_BIT_PWR];
      next_st.host_mode    = wdata_in[`UIF_BIT_HOST];
    end

    // Busy tracks running, then a drain period after power is removed.
    case (st.power)
      uif_pkg::UIF_OFF:
        if (st.power_enable)
          next_st.power = uif_pkg::UIF_ON;
      uif_pkg::UIF_ON:
        if (!st.power_enable)
        begin
          next_st.power    = uif_pkg::UIF_DRAIN;
          next_st.busy_cnt = 5'(`UIF_BUSY_CYCLES);
        end
      uif_pkg::UIF_DRAIN:
        if (st.busy_cnt != 5'h00)
          next_st.busy_cnt = st.busy_cnt - 5'h01;
        else if (!engine_busy_in)
          next_st.power = uif_pkg::UIF_OFF;
      default:
        next_st.power = uif_pkg::UIF_OFF;
    endcase

    next_st.rdata = `UIF_ZERO32;
    if (read_in)
    begin
      case (addr_in)
        `UIF_OFS_POWER:
        begin
          next_st.rdata[`UIF_BIT_PWR]  = st.power_enable;
          next_st.rdata[`UIF_BIT_HOST] = st.host_mode;
          next_st.rdata[`UIF_BIT_BUSY] = (st.power != uif_pkg::UIF_OFF) || st.power_enable;
        end
        `UIF_OFS_FLAGS:      next_st.rdata[7:0] = st.flags;
        `UIF_OFS_ENABLES:    next_st.rdata[7:0] = st.enables;
        `UIF_OFS_ERR_ENABLE: next_st.rdata[7:0] = st.err_enables;
        `UIF_OFS_ERR_FLAGS:  next_st.rdata[7:0] = st.err_flags;
        `UIF_OFS_TOKEN_STAT: next_st.rdata[7:0] = token_status_in;
        default:             next_st.rdata = `UIF_ZERO32;
      endcase
    end

    if (reset_in)
    begin
      next_st = '0;
      next_st.power = uif_pkg::UIF_OFF;
    end
  end

  always_ff @(posedge clock_in)
  begin
    st <= next_st;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // The error summary only counts when its own enable is set.
  assign module_interrupt_request_out = |(st.flags & st.enables) && st.power_enable;
  assign rdata_out                    = st.rdata;
  assign module_enable_out            = st.power_enable;
  assign host_mode_out                = st.host_mode;
  // A one written to the token flag while it is set pops the next entry.
  assign token_fifo_advance_out       = wr_flags && wdata_in[`UIF_BIT_TOKEN]
                                        && st.flags[`UIF_BIT_TOKEN];

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_clear_token;
    write_in && addr_in == `UIF_OFS_FLAGS && wdata_in[`UIF_BIT_TOKEN] && !events_in.token_done;
  endsequence

  chk_flag_clear: assert property (@(posedge clock_in) disable iff (reset_in)
    s_clear_token |=> !st.flags[`UIF_BIT_TOKEN])
    else $error("token flag not cleared by write of one");
  chk_flag_hold: assert property (@(posedge clock_in) disable iff (reset_in)
    (st.flags[`UIF_BIT_STALL] && !(write_in && addr_in == `UIF_OFS_FLAGS)) |=> st.flags[`UIF_BIT_STALL])
    else $error("stall flag lost without clear");
  chk_stall_set: assert property (@(posedge clock_in) disable iff (reset_in)
    (events_in.stall && st.power_enable) |=> st.flags[`UIF_BIT_STALL])
    else $error("stall event did not set flag");
  chk_upper_zero: assert property (@(posedge clock_in) disable iff (reset_in)
    $past(read_in) && $past(addr_in) == `UIF_OFS_FLAGS |-> rdata_out[31:8] == 24'h000000)
    else $error("upper flag bits not zero");
  chk_err_summary: assert property (@(posedge clock_in) disable iff (reset_in)
    ##1 st.flags[`UIF_BIT_ERROR] == |($past(st.err_flags) & $past(st.err_enables)))
    else $error("error summary mismatch");
  chk_irq_level: assert property (@(posedge clock_in) disable iff (reset_in)
    (|(st.flags & st.enables) && st.power_enable) |-> module_interrupt_request_out)
    else $error("interrupt request missing");
  chk_off_quiet: assert property (@(posedge clock_in) disable iff (reset_in)
    !st.power_enable |-> !module_interrupt_request_out)
    else $error("interrupt while disabled");
  chk_bit0_mode: assert property (@(posedge clock_in) disable iff (reset_in)
    (st.power_enable && st.host_mode && events_in.detach) |=> st.flags[`UIF_BIT_RESET])
    else $error("detach did not set bit zero");
  chk_fifo_pop: assert property (@(posedge clock_in) disable iff (reset_in)
    (s_clear_token and st.flags[`UIF_BIT_TOKEN]) |-> token_fifo_advance_out)
    else $error("token fifo not advanced");

  // --------------------------------------------------------------------------
  // Bus access steps
  // --------------------------------------------------------------------------
  // Named steps keep the register checks below readable as a walk.
  sequence s_write_flags;
    write_in && addr_in == `UIF_OFS_FLAGS;
  endsequence

  sequence s_write_enables;
    write_in && addr_in == `UIF_OFS_ENABLES;
  endsequence

  sequence s_read_power;
    read_in && addr_in == `UIF_OFS_POWER;
  endsequence

  sequence s_read_unmapped;
    read_in && addr_in != `UIF_OFS_POWER && addr_in != `UIF_OFS_FLAGS
      && addr_in != `UIF_OFS_ENABLES && addr_in != `UIF_OFS_ERR_ENABLE
      && addr_in != `UIF_OFS_ERR_FLAGS && addr_in != `UIF_OFS_TOKEN_STAT;
  endsequence

  // --------------------------------------------------------------------------
  // Register checks
  // --------------------------------------------------------------------------
  // chk_flags_reset and chk_enables_reset run through reset on purpose, since they check what reset leaves behind.
  chk_flags_reset: assert property (@(posedge clock_in)
    reset_in |=> (st.flags == `UIF_ZERO8))
    else $error("flags not zero after reset");

  chk_enables_reset: assert property (@(posedge clock_in)
    reset_in |=> (st.enables == `UIF_ZERO8))
    else $error("enables not zero after reset");

  chk_enable_write: assert property (@(posedge clock_in) disable iff (reset_in)
    s_write_enables |=> (st.enables == $past(wdata_in[`UIF_FLAG_W-1:0])))
    else $error("enable write not taken");

  chk_write_zero: assert property (@(posedge clock_in) disable iff (reset_in)
    (s_write_flags ##0 (!wdata_in[`UIF_BIT_STALL] && st.flags[`UIF_BIT_STALL]))
    |=> st.flags[`UIF_BIT_STALL])
    else $error("zero write changed a flag");

  chk_set_wins: assert property (@(posedge clock_in) disable iff (reset_in)
    (s_write_flags ##0 (wdata_in[`UIF_BIT_TOKEN] && events_in.token_done && st.power_enable))
    |=> st.flags[`UIF_BIT_TOKEN])
    else $error("clear beat a simultaneous set");

  chk_enable_upper: assert property (@(posedge clock_in) disable iff (reset_in)
    (read_in && addr_in == `UIF_OFS_ENABLES) |=> (rdata_out[31:8] == `UIF_ZERO24))
    else $error("upper enable bits not zero");

  chk_unmapped_zero: assert property (@(posedge clock_in) disable iff (reset_in)
    s_read_unmapped |=> (rdata_out == `UIF_ZERO32))
    else $error("unmapped read not zero");

  chk_rdata_idle: assert property (@(posedge clock_in) disable iff (reset_in)
    !read_in |=> (rdata_out == `UIF_ZERO32))
    else $error("read data outside its cycle");

  chk_power_write: assert property (@(posedge clock_in) disable iff (reset_in)
    (write_in && addr_in == `UIF_OFS_POWER) |=> (module_enable_out == $past(wdata_in[0])))
    else $error("power enable write not taken");

  chk_stall_off: assert property (@(posedge clock_in) disable iff (reset_in)
    (!st.power_enable && !st.flags[`UIF_BIT_STALL]) |=> !st.flags[`UIF_BIT_STALL])
    else $error("flag set while disabled");

  // --------------------------------------------------------------------------
  // Event checks
  // --------------------------------------------------------------------------
  chk_resume_set: assert property (@(posedge clock_in) disable iff (reset_in)
    ($rose(st.k_seen) && $past(st.power_enable)) |-> st.flags[`UIF_BIT_RESUME])
    else $error("resume flag missing");

  chk_idle_set: assert property (@(posedge clock_in) disable iff (reset_in)
    ($rose(st.idle_seen) && $past(st.power_enable)) |-> st.flags[`UIF_BIT_IDLE])
    else $error("idle flag missing");

  chk_token_set: assert property (@(posedge clock_in) disable iff (reset_in)
    (st.power_enable && events_in.token_done) |=> st.flags[`UIF_BIT_TOKEN])
    else $error("token flag missing");

  chk_sof_device: assert property (@(posedge clock_in) disable iff (reset_in)
    (st.power_enable && !st.host_mode && events_in.sof_rx) |=> st.flags[`UIF_BIT_SOF])
    else $error("frame start flag missing in device mode");

  chk_sof_host: assert property (@(posedge clock_in) disable iff (reset_in)
    (st.power_enable && st.host_mode && events_in.sof_threshold) |=> st.flags[`UIF_BIT_SOF])
    else $error("frame start flag missing in host mode");

  chk_reset_device: assert property (@(posedge clock_in) disable iff (reset_in)
    (st.power_enable && !st.host_mode && events_in.bus_reset) |=> st.flags[`UIF_BIT_RESET])
    else $error("bus reset did not set bit zero");

  chk_attach_device: assert property (@(posedge clock_in) disable iff (reset_in)
    (!st.host_mode && !st.flags[`UIF_BIT_ATTACH]) |=> !st.flags[`UIF_BIT_ATTACH])
    else $error("attach flag set outside host mode");

  chk_attach_se0: assert property (@(posedge clock_in) disable iff (reset_in)
    (st.aux_s2[1] && !st.flags[`UIF_BIT_ATTACH]) |=> !st.flags[`UIF_BIT_ATTACH])
    else $error("attach flag set during SE0");

  chk_err_flag_set: assert property (@(posedge clock_in) disable iff (reset_in)
    (st.power_enable && |error_events_in) |=> |st.err_flags)
    else $error("error event lost");

  chk_summary_ro: assert property (@(posedge clock_in) disable iff (reset_in)
    (s_write_flags ##0 |(st.err_flags & st.err_enables)) |=> st.flags[`UIF_BIT_ERROR])
    else $error("error summary cleared by a write");

  // --------------------------------------------------------------------------
  // Busy and request checks
  // --------------------------------------------------------------------------
  // A power-down is followed by a drain, so busy must not drop at once.
  chk_busy_on: assert property (@(posedge clock_in) disable iff (reset_in)
    (s_read_power ##0 st.power_enable) |=> rdata_out[`UIF_BIT_BUSY])
    else $error("busy low while running");

  chk_busy_idle: assert property (@(posedge clock_in) disable iff (reset_in)
    (s_read_power ##0 (st.power == uif_pkg::UIF_OFF && !st.power_enable))
    |=> !rdata_out[`UIF_BIT_BUSY])
    else $error("busy high while idle");

  chk_drain_hold: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(st.power_enable) |=> (st.power == uif_pkg::UIF_DRAIN) [*8])
    else $error("drain ended too early");

  chk_err_gate: assert property (@(posedge clock_in) disable iff (reset_in)
    (st.flags == `UIF_ERR_MASK && !st.enables[`UIF_BIT_ERROR]) |-> !module_interrupt_request_out)
    else $error("masked error raised the request");

  chk_irq_low: assert property (@(posedge clock_in) disable iff (reset_in)
    ((st.flags & st.enables) == `UIF_ZERO8) |-> !module_interrupt_request_out)
    else $error("request with no enabled flag");

  chk_fifo_only: assert property (@(posedge clock_in) disable iff (reset_in)
    token_fifo_advance_out |-> (s_write_flags ##0 st.flags[`UIF_BIT_TOKEN]))
    else $error("token fifo advanced without a clear");

endmodule

// ===== verilog/uif_defines.svh
// Offsets, field positions, reset values and timing counts of the USB interrupt flag block.
`ifndef UIF_DEFINES_SVH
`define UIF_DEFINES_SVH

// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define UIF_ADDR_W          8
`define UIF_OFS_POWER       8'h00
`define UIF_OFS_FLAGS       8'h04
`define UIF_OFS_ENABLES     8'h08
`define UIF_OFS_ERR_ENABLE  8'h0C
`define UIF_OFS_ERR_FLAGS   8'h10
`define UIF_OFS_TOKEN_STAT  8'h14

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define UIF_BIT_PWR         0
`define UIF_BIT_BUSY        3
`define UIF_BIT_STALL       7
`define UIF_BIT_ATTACH      6
`define UIF_BIT_RESUME      5
`define UIF_BIT_IDLE        4
`define UIF_BIT_TOKEN       3
`define UIF_BIT_SOF         2
`define UIF_BIT_ERROR       1
`define UIF_BIT_RESET       0
`define UIF_BIT_HOST        1
`define UIF_ERR_MASK        8'h02
`define UIF_ZERO24          24'h000000
`define UIF_FLAG_W          8
`define UIF_ZERO8           8'h00
`define UIF_ZERO32          32'h0000_0000

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define UIF_CLK_NS          8
`define UIF_K_TIME_NS       2500
`define UIF_IDLE_TIME_NS    3000000
`define UIF_QUIET_NS        2500
`define UIF_K_CYCLES        ((`UIF_K_TIME_NS + `UIF_CLK_NS - 1) / `UIF_CLK_NS)
`define UIF_QUIET_CYCLES    ((`UIF_QUIET_NS + `UIF_CLK_NS - 1) / `UIF_CLK_NS)
`define UIF_IDLE_CYCLES     ((`UIF_IDLE_TIME_NS + `UIF_CLK_NS - 1) / `UIF_CLK_NS)
`define UIF_BUSY_CYCLES     16
`define UIF_CNT_W           20

`endif

// ===== verilog/uif_pkg.sv
// Types shared by the USB interrupt flag block.
package uif_pkg;

  typedef enum logic [2:0]
  {
    UIF_OFF   = 3'b001,
    UIF_ON    = 3'b010,
    UIF_DRAIN = 3'b100
  } uif_power_t;

  typedef struct packed
  {
    logic stall;
    logic sof_rx;
    logic sof_threshold;
    logic token_done;
    logic bus_reset;
    logic detach;
    logic attach;
  } uif_event_t;

  typedef struct packed
  {
    logic       k_state;
    logic       idle_state;
    logic       se0;
    logic       activity;
  } uif_line_t;

  typedef struct packed
  {
    uif_power_t  power;
    logic [4:0]  busy_cnt;
    logic        power_enable;
    logic        host_mode;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [7:0]  err_enables;
    logic [7:0]  err_flags;
    logic [19:0] k_cnt;
    logic [19:0] idle_cnt;
    logic [19:0] quiet_cnt;
    logic        idle_seen;
    logic        k_seen;
    logic [1:0]  line_s1;
    logic [1:0]  line_s2;
    logic [1:0]  aux_s1;
    logic [1:0]  aux_s2;
    logic [31:0] rdata;
  } uif_state_t;

endpackage
